// ### logic/acpc_top.sv
`timescale 1ns/1ps
`include "acpc_defs.svh"

///////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - stop powers converter down like cleared enable
// - wait with stop-in-wait set powers down
// - stop-in-wait clear ignores wait
// - registers unreachable during wait power-down
// - two-bit freeze field selects freeze response
// - deferred freeze halts before next sample
// - immediate freeze halts at once
// - frozen state kept, resumes on release
// - registers accessible while frozen
// - system reset or soft-reset bit resets
// - soft reset keeps power-up enable
// - reset aborts sequence, clears flags, interrupt
// - reset restores control, test, status
// - leaving wait resumes without reset
// - freeze never resets converter
// - power-up enable initialises no register
// - sequence register write restarts sequence
// - analog pins readable as digital port
// - port read leaves conversion undisturbed
// - power-up enable resets to zero
// - stop or cleared enable aborts running sequence
module acpc_top (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  // wishbone slave
  input  wire logic        I_WB_CYC,
  input  wire logic        I_WB_STB,
  input  wire logic        I_WB_WE,
  input  wire logic [4:0]  I_WB_ADR,
  input  wire logic [3:0]  I_WB_SEL,
  input  wire logic [31:0] I_WB_DAT,
  output logic      [31:0] O_WB_DAT,
  output logic             O_WB_ACK,
  // processor low-power and debug
  input  wire logic        I_STOP,
  input  wire logic        I_WAIT,
  input  wire logic        I_DBG_FREEZE,
  // analog pins as digital inputs
  input  wire logic [7:0]  I_ANALOG_PINS,
  // converter status
  output logic             O_POWERED,
  output logic             O_BUSY,
  output logic             O_FROZEN,
  output logic             O_SEQ_DONE_IRQ
);

  /////////////////////////////////////////////////////////////////////////////
  // state of the module
  typedef struct packed {
    logic [7:0]              ctl2;     // power, wait, irq enable
    logic [7:0]              ctl3;     // freeze field
    logic [7:0]              seq4;     // sequence setup
    logic [7:0]              seq5;     // sequence start
    logic                    soft_rst; // test register soft reset
    logic [7:0]              ccf;      // conversion complete flags
    logic                    scf;      // sequence complete flag
    acpc_pkg::acpc_state_t   state;    // sequencer state
    logic [3:0]              tcnt;     // timing position
    logic [2:0]              chan;     // current channel
    logic                    frozen;   // halted by debug
    logic [31:0]             rdat;     // bus read data
    logic                    ack;      // bus acknowledge
    logic                    powered;  // registered power state
    logic                    irq;      // registered interrupt
    logic                    busy;     // registered sequencer activity
  } acpc_regs_t;

  acpc_regs_t st_reg;  // registered state
  acpc_regs_t st_next; // next state

  /////////////////////////////////////////////////////////////////////////////
  // helpers
  // decode a freeze field into stop-now / stop-at-boundary
  function automatic logic frz_hard(input logic [1:0] f);
    frz_hard = (f == `ACPC_FRZ_HARD);
  endfunction

  function automatic logic frz_soft(input logic [1:0] f);
    frz_soft = (f == `ACPC_FRZ_SOFT);
  endfunction

  /////////////////////////////////////////////////////////////////////////////
  // combinational decode
  logic       wb_req;     // valid new bus request
  logic       wb_wr;      // write strobe
  logic       wb_rd;      // read strobe
  logic       page_hi;    // upper register page
  logic       power_on;   // analog and clocks enabled
  logic       wait_off;   // powered down by wait
  logic [1:0] frz_field;  // freeze response
  logic       halt_now;   // freeze stops this cycle
  logic [7:0] ctl2_w;     // ctl2 write data
  logic       pwr_cut;    // enable clear or stop: abort
  logic       seq_wr;     // write to a sequence register
  logic       port_rd;    // digital port read

  assign frz_field = st_reg.ctl3[`ACPC_CTL3_FRZ_HI:`ACPC_CTL3_FRZ_LO];
  assign wait_off  = I_WAIT & st_reg.ctl2[`ACPC_CTL2_SWAI];
  assign power_on  = st_reg.ctl2[`ACPC_CTL2_PU] & ~I_STOP & ~wait_off;
  // enable clear and stop abort the sequence
  // wait only pauses it, so it is left out here
  assign pwr_cut   = ~st_reg.ctl2[`ACPC_CTL2_PU] | I_STOP;
  assign wb_req    = I_WB_CYC & I_WB_STB & ~st_reg.ack & ~wait_off;
  assign wb_wr     = wb_req & I_WB_WE & I_WB_SEL[0];
  assign wb_rd     = wb_req & ~I_WB_WE;
  assign page_hi   = I_WB_ADR[`ACPC_PAGE_BIT];
  assign ctl2_w    = I_WB_DAT[7:0];
  assign seq_wr    = wb_wr && !page_hi &&
                     (I_WB_ADR[3:0] == `ACPC_OFS_SEQ4 ||
                      I_WB_ADR[3:0] == `ACPC_OFS_SEQ5);
  // port reads are watched by a check below
  assign port_rd   = wb_rd && page_hi &&
                     I_WB_ADR[3:0] == `ACPC_OFS_PORT;
  // hard freeze halts at once; deferred only before a sample starts
  assign halt_now  = I_DBG_FREEZE & (frz_hard(frz_field) |
                     (frz_soft(frz_field) &&
                      st_reg.state != acpc_pkg::ACPC_CONVERT &&
                      st_reg.tcnt == `ACPC_ZERO4));

  /////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    st_next     = st_reg;
    st_next.ack = 1'b0;
    // bus acknowledge one cycle after request
    if (wb_req) begin
      st_next.ack = 1'b1;
    end
    // bus works while frozen
    // read data is zero unless a read is taken
    st_next.rdat = `ACPC_ZERO32;
    if (wb_rd) begin
      if (!page_hi) begin
        unique case (I_WB_ADR[3:0])
          `ACPC_OFS_CTL2: st_next.rdat[7:0] = st_reg.ctl2;
          `ACPC_OFS_CTL3: st_next.rdat[7:0] = st_reg.ctl3;
          `ACPC_OFS_SEQ4: st_next.rdat[7:0] = st_reg.seq4;
          `ACPC_OFS_SEQ5: st_next.rdat[7:0] = st_reg.seq5;
          default:        st_next.rdat      = `ACPC_ZERO32;
        endcase
      end else begin
        unique case (I_WB_ADR[3:0])
          `ACPC_OFS_TEST: st_next.rdat[0]   = st_reg.soft_rst;
          `ACPC_OFS_STAT: st_next.rdat[8:0] = {st_reg.scf, st_reg.ccf};
          `ACPC_OFS_PORT: st_next.rdat[7:0] = I_ANALOG_PINS;
          `ACPC_OFS_RES:  st_next.rdat[7:0] = {`ACPC_ZERO4, st_reg.tcnt};
          default:        st_next.rdat      = `ACPC_ZERO32;
        endcase
      end
    end
    // register writes
    if (wb_wr && !page_hi) begin
      unique case (I_WB_ADR[3:0])
        `ACPC_OFS_CTL2: st_next.ctl2 = ctl2_w;
        `ACPC_OFS_CTL3: st_next.ctl3 = I_WB_DAT[7:0];
        `ACPC_OFS_SEQ4: st_next.seq4 = I_WB_DAT[7:0];
        `ACPC_OFS_SEQ5: st_next.seq5 = I_WB_DAT[7:0];
        default:        st_next.ctl3 = st_reg.ctl3;
      endcase
    end
    if (wb_wr && page_hi && I_WB_ADR[3:0] == `ACPC_OFS_TEST) begin
      st_next.soft_rst = I_WB_DAT[`ACPC_TEST_RST];
    end
    // sequencer
    // frozen keeps timing position
    st_next.frozen = halt_now;
    if (pwr_cut) begin
      st_next.state = acpc_pkg::ACPC_IDLE;
      st_next.tcnt  = `ACPC_ZERO4;
    end else if (wait_off) begin
      // wait power-down holds the position
      // so the sequence carries on when wait ends
      st_next.state = st_reg.state;
    end else if (!halt_now) begin
      unique case (st_reg.state)
        acpc_pkg::ACPC_IDLE: begin
          // idle: timing held at zero
          st_next.tcnt = `ACPC_ZERO4;
        end
        acpc_pkg::ACPC_SAMPLE: begin
          if (st_reg.tcnt == `ACPC_SAMPLE_CYC - `ACPC_ONE4) begin
            st_next.state = acpc_pkg::ACPC_CONVERT;
            st_next.tcnt  = `ACPC_ZERO4;
          end else begin
            st_next.tcnt = st_reg.tcnt + `ACPC_ONE4;
          end
        end
        acpc_pkg::ACPC_CONVERT: begin
          if (st_reg.tcnt == `ACPC_CONV_CYC - `ACPC_ONE4) begin
            st_next.tcnt = `ACPC_ZERO4;
            st_next.ccf[st_reg.chan] = 1'b1;
            st_next.chan = st_reg.chan + `ACPC_ONE3;
            if (st_reg.chan == `ACPC_LAST_CH) begin
              st_next.scf   = 1'b1;
              st_next.state = acpc_pkg::ACPC_IDLE;
            end else begin
              st_next.state = acpc_pkg::ACPC_SAMPLE;
            end
          end else begin
            st_next.tcnt = st_reg.tcnt + `ACPC_ONE4;
          end
        end
        // the spare state code falls back to idle
        default: st_next.state = acpc_pkg::ACPC_IDLE;
      endcase
    end
    // new conversion only by software write
    if (seq_wr) begin
      st_next.ccf   = `ACPC_ZERO8;
      st_next.scf   = 1'b0;
      st_next.chan  = `ACPC_ZERO3;
      st_next.tcnt  = `ACPC_ZERO4;
      st_next.state = power_on ? acpc_pkg::ACPC_SAMPLE
                               : acpc_pkg::ACPC_IDLE;
    end
    if (st_reg.soft_rst) begin
      st_next.ctl2     = st_reg.ctl2 & `ACPC_CTL2_KEEP;
      st_next.ctl3     = `ACPC_ZERO8;
      st_next.seq4     = `ACPC_ZERO8;
      st_next.seq5     = `ACPC_ZERO8;
      st_next.soft_rst = 1'b0;
      st_next.ccf      = `ACPC_ZERO8;
      st_next.scf      = 1'b0;
      st_next.state    = acpc_pkg::ACPC_IDLE;
      st_next.tcnt     = `ACPC_ZERO4;
      st_next.chan     = `ACPC_ZERO3;
    end
    st_next.powered = power_on;
    st_next.irq     = st_next.scf & st_next.ctl2[`ACPC_CTL2_SCIE];
    // busy flag registered with the state it mirrors
    st_next.busy    = (st_next.state != acpc_pkg::ACPC_IDLE);
  end

  /////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      st_reg.ctl2     <= `ACPC_ZERO8;
      st_reg.ctl3     <= `ACPC_ZERO8;
      st_reg.seq4     <= `ACPC_ZERO8;
      st_reg.seq5     <= `ACPC_ZERO8;
      st_reg.soft_rst <= 1'b0;
      st_reg.ccf      <= `ACPC_ZERO8;
      st_reg.scf      <= 1'b0;
      st_reg.state    <= acpc_pkg::ACPC_IDLE;
      st_reg.tcnt     <= `ACPC_ZERO4;
      st_reg.chan     <= `ACPC_ZERO3;
      st_reg.frozen   <= 1'b0;
      st_reg.rdat     <= `ACPC_ZERO32;
      st_reg.ack      <= 1'b0;
      st_reg.powered  <= 1'b0;
      st_reg.irq      <= 1'b0;
      st_reg.busy     <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign O_WB_DAT       = st_reg.rdat;
  assign O_WB_ACK       = st_reg.ack;
  assign O_POWERED      = st_reg.powered;
  assign O_BUSY         = st_reg.busy;
  assign O_FROZEN       = st_reg.frozen;
  assign O_SEQ_DONE_IRQ = st_reg.irq;

  /////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_stop_on;
    I_STOP;
  endsequence

  stop_power_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    s_stop_on |=> !O_POWERED)
    else $error("converter powered during stop");

  wait_power_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_WAIT && st_reg.ctl2[`ACPC_CTL2_SWAI]) |=> !O_POWERED)
    else $error("converter powered during enabled wait");

  wait_ignore_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (!st_reg.ctl2[`ACPC_CTL2_SWAI] && st_reg.ctl2[`ACPC_CTL2_PU] && !I_STOP)
    |=> O_POWERED)
    else $error("wait acted while disabled");

  wait_bus_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    wait_off |=> !O_WB_ACK)
    else $error("bus answered during wait power down");

  hard_freeze_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_DBG_FREEZE && frz_field == `ACPC_FRZ_HARD && power_on
     && !st_reg.soft_rst && !wb_wr)
    |=> $stable(st_reg.tcnt) && $stable(st_reg.chan))
    else $error("timing moved while frozen");

  ignore_freeze_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (frz_field == `ACPC_FRZ_IGN2) |=> !O_FROZEN)
    else $error("freeze code 01 did not ignore");

  soft_keep_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    st_reg.soft_rst |=> st_reg.ctl2[`ACPC_CTL2_PU] ==
                        $past(st_reg.ctl2[`ACPC_CTL2_PU]))
    else $error("soft reset changed power bit");

  soft_clear_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    st_reg.soft_rst |=> (st_reg.ccf == `ACPC_ZERO8) && !st_reg.scf
                        && !O_BUSY ##1 !O_SEQ_DONE_IRQ)
    else $error("soft reset left activity");

  power_abort_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (pwr_cut && !wb_wr) |=> !O_BUSY)
    else $error("sequence survived power down");

  // wait power-down must freeze the sequencer, not clear it
  wait_hold_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (wait_off && !pwr_cut && !st_reg.soft_rst)
    |=> $stable(st_reg.state) && $stable(st_reg.tcnt)
        && $stable(st_reg.chan))
    else $error("wait power down lost the sequence position");

  // a restart write not overridden by a soft reset
  sequence s_seq_write;
    seq_wr && !st_reg.soft_rst;
  endsequence

  restart_flags_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    s_seq_write |=> (st_reg.ccf == `ACPC_ZERO8) && !st_reg.scf)
    else $error("restart left completion flags set");

  restart_busy_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (seq_wr && power_on && !st_reg.soft_rst) |=> O_BUSY)
    else $error("restart did not start a sequence");

  // deferred freeze must let a running conversion finish
  soft_freeze_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (I_DBG_FREEZE && frz_field == `ACPC_FRZ_SOFT
     && st_reg.state == acpc_pkg::ACPC_CONVERT) |=> !O_FROZEN)
    else $error("deferred freeze stopped a conversion");

  // a port read while sampling leaves the timing running
  port_read_a: assert property (@(posedge I_CLK) disable iff (I_RST)
    (port_rd && power_on && !halt_now && !st_reg.soft_rst
     && st_reg.state == acpc_pkg::ACPC_SAMPLE
     && st_reg.tcnt != `ACPC_SAMPLE_CYC - `ACPC_ONE4)
    |=> st_reg.tcnt == $past(st_reg.tcnt) + `ACPC_ONE4)
    else $error("port read disturbed the sequence");

endmodule

// ### logic/acpc_defs.svh
`ifndef ACPC_DEFS_SVH
`define ACPC_DEFS_SVH

// register word offsets (byte addresses)
`define ACPC_OFS_CTL2    4'h0
`define ACPC_OFS_CTL3    4'h4
`define ACPC_OFS_SEQ4    4'h8
`define ACPC_OFS_SEQ5    4'hC
`define ACPC_OFS_TEST    4'h0
`define ACPC_OFS_STAT    4'h4
`define ACPC_OFS_PORT    4'h8
`define ACPC_OFS_RES     4'hC

// page select in address bit 4
`define ACPC_PAGE_BIT    4

// second control register fields
`define ACPC_CTL2_PU     7
`define ACPC_CTL2_SWAI   2
`define ACPC_CTL2_SCIE   1
// third control register fields
`define ACPC_CTL3_FRZ_HI 1
`define ACPC_CTL3_FRZ_LO 0
// test register soft reset bit
`define ACPC_TEST_RST    0
// second control register bits kept by a soft reset
`define ACPC_CTL2_KEEP   8'h80

// freeze response codes
`define ACPC_FRZ_IGN     2'h0
`define ACPC_FRZ_IGN2    2'h1
`define ACPC_FRZ_SOFT    2'h2
`define ACPC_FRZ_HARD    2'h3

// reset values
`define ACPC_ZERO8       8'h00
`define ACPC_ZERO32      32'h0000_0000
`define ACPC_ZERO4       4'h0
`define ACPC_ZERO3       3'h0

// sequence timing, in module clocks
`define ACPC_SAMPLE_CYC  4'h8
`define ACPC_CONV_CYC    4'hC
`define ACPC_ONE4        4'h1
`define ACPC_ONE3        3'h1
`define ACPC_LAST_CH     3'h7

`endif

// ### logic/acpc_pkg.sv
package acpc_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    ACPC_IDLE,
    ACPC_SAMPLE,
    ACPC_CONVERT
  } acpc_state_t;
endpackage

// ### dv/acpc_cpu_model.sv
`timescale 1ns/1ps
// processor side: bus master, low-power and debug lines, pin levels
module acpc_cpu_model #(
  parameter int SETTLE_CYC = 4  // analog settling wait, in clocks
) (
  // clock
  input  wire logic        i_clk,
  // wishbone master
  output logic             o_cyc,
  output logic             o_stb,
  output logic             o_we,
  output logic [4:0]       o_adr,
  output logic [31:0]      o_dat,
  input  wire logic [31:0] i_dat,
  input  wire logic        i_ack,
  // core state and pins
  output logic             o_stop,
  output logic             o_wait,
  output logic             o_frz,
  output logic [7:0]       o_pins
);
  logic swai = 1'h0;  // stop-in-wait as last written
  initial begin
    {o_cyc, o_stb, o_we, o_stop, o_wait, o_frz} = 6'h00;
    o_adr = 5'h00;
    o_dat = 32'h0000_0000;
    o_pins = 8'h00;
  end
  // one classic cycle, held until ack is seen at a rising edge
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic ok);
    int n;
    n = 0;
    // no request while powered down by wait
    while (o_wait && swai) @(posedge i_clk);
    @(posedge i_clk);
    {o_cyc, o_stb, o_we} <= {2'h3, w};
    o_adr <= a;
    o_dat <= d;
    // edge by edge; only the bench watchdog ends a lost answer
    do begin
      @(posedge i_clk);
      n++;
    end while (i_ack !== 1'h1);
    // ack is due one cycle after the taking edge
    ok = (n == 2);
    q = i_dat;
    {o_cyc, o_stb, o_we} <= 3'h0;
    if (w && a == 5'h00) swai = d[2];
    // a soft reset clears stop-in-wait as well
    if (w && a == 5'h10 && d[0]) swai = 1'h0;
  endtask
  // low-power and debug lines change after an edge
  task automatic lines(input logic s, input logic wt, input logic f);
    @(posedge i_clk);
    {o_stop, o_wait, o_frz} <= {s, wt, f};
  endtask
  task automatic pins(input logic [7:0] p);
    @(posedge i_clk);
    o_pins <= p;
  endtask
  // host allows bias to settle before a new sequence
  task automatic settle();
    repeat (SETTLE_CYC) @(posedge i_clk);
  endtask
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ps
// converter control bench
module tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic cyc, stb, we, ack, stop, wt, frz;
  logic [4:0] adr;
  logic [31:0] wdat, rdat;
  logic [7:0] pins;
  logic powered, busy, frozen, irq;
  int failures = 0;
  int checks_done = 0;
  always #10 clk = ~clk;
  acpc_top dut (.I_CLK(clk), .I_RST(rst), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_STOP(stop), .I_WAIT(wt),
    .I_DBG_FREEZE(frz), .I_ANALOG_PINS(pins), .O_POWERED(powered),
    .O_BUSY(busy), .O_FROZEN(frozen), .O_SEQ_DONE_IRQ(irq));
  acpc_cpu_model cpu (.i_clk(clk), .o_cyc(cyc), .o_stb(stb), .o_we(we),
    .o_adr(adr), .o_dat(wdat), .i_dat(rdat), .i_ack(ack), .o_stop(stop),
    .o_wait(wt), .o_frz(frz), .o_pins(pins));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chkb(input string nm, input logic s, e);
    chk(nm, {31'h0, s}, {31'h0, e});
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    logic ok;
    cpu.xfer(w, a, d, q, ok);
    chkb("bus ack", ok, 1'h1);
    @(negedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e,
                     input string nm);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic idle_wait();
    for (int n = 0; n < 400 && busy !== 1'h0; n++) @(negedge clk);
  endtask
  task automatic close_out();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog, well beyond the roughly 1350 clocks the tests need
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chkb("powered at reset", powered, 1'h0);
    rdc(5'h00, 32'h0000_0000, "ctl2 reset");
    rdc(5'h14, 32'h0000_0000, "status reset");
    rdc(5'h13, 32'h0000_0000, "unmapped");
    wr(5'h04, 32'h0000_0001);
    wr(5'h00, 32'h0000_0082);
    rdc(5'h04, 32'h0000_0001, "ctl3 after power up");
    cpu.settle();
    cpu.pins(8'hA5);
    rdc(5'h18, 32'h0000_00A5, "port");
    // port read in mid-sequence must not disturb it
    wr(5'h0C, 32'h0000_0000);
    cpu.pins(8'h3C);
    rdc(5'h18, 32'h0000_003C, "port busy");
    chkb("busy after port read", busy, 1'h1);
    idle_wait();
    rdc(5'h14, 32'h0000_01FF, "status done");
    chkb("irq done", irq, 1'h1);
    wr(5'h08, 32'h0000_0000);
    chkb("irq after restart", irq, 1'h0);
    repeat (30) @(negedge clk);
    wr(5'h0C, 32'h0000_0000);
    rdc(5'h14, 32'h0000_0000, "flags after restart");
    chkb("busy after restart", busy, 1'h1);
    // stop aborts and powers down, registers kept
    cpu.lines(1'h1, 1'h0, 1'h0);
    repeat (3) @(negedge clk);
    chkb("powered in stop", powered, 1'h0);
    chkb("busy in stop", busy, 1'h0);
    cpu.lines(1'h0, 1'h0, 1'h0);
    repeat (3) @(negedge clk);
    chkb("idle after stop", busy, 1'h0);
    rdc(5'h00, 32'h0000_0082, "ctl2 after stop");
    // wait ignored while stop-in-wait clear
    cpu.lines(1'h0, 1'h1, 1'h0);
    rdc(5'h00, 32'h0000_0082, "ctl2 in wait");
    chkb("powered in wait", powered, 1'h1);
    cpu.lines(1'h0, 1'h0, 1'h0);
    // wait with stop-in-wait set powers down, then resumes
    wr(5'h00, 32'h0000_0086);
    cpu.settle();
    wr(5'h0C, 32'h0000_0000);
    repeat (30) @(negedge clk);
    cpu.lines(1'h0, 1'h1, 1'h0);
    repeat (3) @(negedge clk);
    chkb("powered in wait", powered, 1'h0);
    repeat (50) @(negedge clk);
    cpu.lines(1'h0, 1'h0, 1'h0);
    repeat (3) @(negedge clk);
    chkb("busy after wait", busy, 1'h1);
    idle_wait();
    rdc(5'h14, 32'h0000_01FF, "status after wait");
    // soft reset keeps power enable, clears the rest
    wr(5'h04, 32'h0000_0003);
    wr(5'h10, 32'h0000_0001);
    chkb("irq after soft reset", irq, 1'h0);
    chkb("powered after soft reset", powered, 1'h1);
    rdc(5'h00, 32'h0000_0080, "ctl2 soft reset");
    rdc(5'h04, 32'h0000_0000, "ctl3 soft reset");
    rdc(5'h14, 32'h0000_0000, "status soft reset");
    rdc(5'h10, 32'h0000_0000, "test soft reset");
    wr(5'h0C, 32'h0000_0000);
    repeat (30) @(negedge clk);
    wr(5'h10, 32'h0000_0001);
    chkb("busy soft reset", busy, 1'h0);
    // every freeze response code
    for (int c = 0; c < 4; c++) begin
      wr(5'h04, 32'(c));
      wr(5'h0C, 32'h0000_0000);
      repeat (10) @(negedge clk);
      cpu.lines(1'h0, 1'h0, 1'h1);
      repeat (3) @(negedge clk);
      chkb("frozen at once", frozen, c == 3);
      for (int n = 0; n < 40 && frozen !== 1'h1; n++) @(negedge clk);
      chkb("frozen later", frozen, c >= 2);
      if (c >= 2) begin
        repeat (50) @(negedge clk);
        rdc(5'h14, 32'(c == 2), "status frozen");
        chkb("busy frozen", busy, 1'h1);
        wr(5'h04, 32'(c));
        rdc(5'h04, 32'(c), "ctl3 frozen");
      end
      cpu.lines(1'h0, 1'h0, 1'h0);
      idle_wait();
      rdc(5'h14, 32'h0000_01FF, "status after freeze");
    end
    // system reset restores power enable to zero
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chkb("powered after reset", powered, 1'h0);
    rdc(5'h00, 32'h0000_0000, "ctl2 after reset");
    close_out();
  end
endmodule
